// File: acr_pkg.sv
package acr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses (special-function-register space, byte wide)
  localparam logic [7:0] ADDR_GAIN_CAL_LOW     = 8'hab;
  localparam logic [7:0] ADDR_GAIN_CAL_MID     = 8'hac;
  localparam logic [7:0] ADDR_GAIN_CAL_HIGH    = 8'had;
  localparam logic [7:0] ADDR_SINC3_RESULT_LOW = 8'hc3;
  localparam logic [7:0] ADDR_SINC3_RESULT_MID = 8'hc4;
  localparam logic [7:0] ADDR_SINC3_RESULT_HIGH = 8'hc5;
  localparam logic [7:0] ADDR_INPUT_MUX_CONTROL = 8'hc6;
  localparam logic [7:0] ADDR_FAST_RESULT_LOW  = 8'hfc;
  localparam logic [7:0] ADDR_FAST_RESULT_MID  = 8'hfd;
  localparam logic [7:0] ADDR_FAST_RESULT_HIGH = 8'hfe;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_GAIN_CAL_HIGH = 8'h80;
  localparam logic [7:0] RST_ZERO          = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // multiplexer field positions and codes
  localparam int         POS_SEL_LSB  = 4;
  localparam int         NEG_SEL_LSB  = 0;
  localparam int         SEL_W        = 4;
  localparam logic [3:0] SEL_TEMP     = 4'hf;
  localparam logic [3:0] SEL_EXT_MAX  = 4'h7;
  localparam int         NUM_EXT      = 8;

  // unmapped reads return this value
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // decoded source of one converter input
  typedef enum logic [1:0] {
    ACR_SRC_EXT,
    ACR_SRC_GND,
    ACR_SRC_TEMP
  } acr_src_t;

endpackage

// File: acr_byte_reg.sv
`timescale 1ns/1ps
`default_nettype none

// one byte register: software write, hardware load, registered read-out
module acr_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  // software side
  input  wire logic       i_sw_we,
  input  wire logic [7:0] i_sw_data,
  // hardware side
  input  wire logic       i_hw_we,
  input  wire logic [7:0] i_hw_data,
  // stored value
  output logic      [7:0] o_value
);

  // hardware load wins over a software write in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_value <= RESET_VALUE;
    end else if (i_hw_we) begin
      o_value <= i_hw_data;
    end else if (i_sw_we) begin
      o_value <= i_sw_data;
    end
  end

endmodule // acr_byte_reg

`default_nettype wire

// File: acr_regs.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE1] gain calibration is 24 bits in three read/write bytes at 0xad, 0xac, 0xab
// [RULE2] gain high byte resets to 0x80; middle and low bytes reset to zero
// [RULE3] sinc3 result is three bytes, high 0xc5, low 0xc3, reset zero
// [RULE4] fast result is three bytes, high 0xfe, low 0xfc, reset zero
// [RULE5] positive and negative inputs each select from ten sources independently
// [RULE6] selecting the temperature sensor on either input enables it automatically
// [RULE7] single-ended and differential both allowed; ground one input for single-ended
// [RULE8] mux register 0xc6: upper nibble positive, lower negative, 0000-0111 external, 1111 temp, else ground
// [RULE9] all three bytes of a result update together on conversion complete
module acr_regs (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // converter core results
  input  wire logic        i_sinc3_done,
  input  wire logic [23:0] i_sinc3_result,
  input  wire logic        i_fast_done,
  input  wire logic [23:0] i_fast_result,
  // to converter core
  output logic      [23:0] o_gain_cal,
  output logic      [3:0]  o_positive_source_select,
  output logic      [3:0]  o_negative_source_select,
  output logic      [7:0]  o_positive_ext_en,
  output logic      [7:0]  o_negative_ext_en,
  output logic             o_positive_gnd_en,
  output logic             o_negative_gnd_en,
  output logic             o_positive_temp_en,
  output logic             o_negative_temp_en,
  output logic             o_temp_sensor_en
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // classify a multiplexer code into its source
  function automatic acr_pkg::acr_src_t decode_src(input logic [3:0] code);
    acr_pkg::acr_src_t src;
    src = acr_pkg::ACR_SRC_GND;
    if (code <= acr_pkg::SEL_EXT_MAX) begin
      src = acr_pkg::ACR_SRC_EXT;
    end else if (code == acr_pkg::SEL_TEMP) begin
      src = acr_pkg::ACR_SRC_TEMP;
    end
    return src;
  endfunction

  // one-hot external input enable for a multiplexer code
  function automatic logic [7:0] ext_onehot(input logic [3:0] code);
    logic [7:0] hot;
    hot = 8'h00;
    if (decode_src(code) == acr_pkg::ACR_SRC_EXT) begin
      hot[code[2:0]] = 1'b1;
    end
    return hot;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second edge

  logic        ack;
  logic        req;
  logic        wr_strobe;
  logic [7:0]  wdata;

  // a write lands only at the edge where waitrequest is seen low (ack cycle)
  assign req       = (i_avs_read || i_avs_write) && !ack;
  assign wr_strobe = i_avs_write && ack && i_avs_byteenable[0];
  assign wdata     = i_avs_writedata[7:0];

  // ack goes high for one cycle after each request is seen
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req;
    end
  end

  // waitrequest drops in the cycle that the answer stands
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte registers: index 0..2 gain, 3..5 sinc3, 6..8 fast (low, mid, high)

  localparam int NUM_REGS = 9;

  logic [7:0] reg_addr  [NUM_REGS];
  logic       reg_hw_we [NUM_REGS];
  logic [7:0] reg_hw_d  [NUM_REGS];
  logic [7:0] reg_value [NUM_REGS];

  // address and reset map
  assign reg_addr[0] = acr_pkg::ADDR_GAIN_CAL_LOW;      // see [RULE1]
  assign reg_addr[1] = acr_pkg::ADDR_GAIN_CAL_MID;      // see [RULE1]
  assign reg_addr[2] = acr_pkg::ADDR_GAIN_CAL_HIGH;     // see [RULE1]
  assign reg_addr[3] = acr_pkg::ADDR_SINC3_RESULT_LOW;  // see [RULE3]
  assign reg_addr[4] = acr_pkg::ADDR_SINC3_RESULT_MID;
  assign reg_addr[5] = acr_pkg::ADDR_SINC3_RESULT_HIGH; // see [RULE3]
  assign reg_addr[6] = acr_pkg::ADDR_FAST_RESULT_LOW;   // see [RULE4]
  assign reg_addr[7] = acr_pkg::ADDR_FAST_RESULT_MID;
  assign reg_addr[8] = acr_pkg::ADDR_FAST_RESULT_HIGH;  // see [RULE4]

  // hardware loads: whole result at once, gain never hardware loaded
  always_comb begin
    for (int k = 0; k < NUM_REGS; k++) begin
      reg_hw_we[k] = 1'b0;
      reg_hw_d[k]  = 8'h00;
    end
    for (int k = 0; k < 3; k++) begin
      reg_hw_we[3 + k] = i_sinc3_done;                  // see [RULE9]
      reg_hw_d[3 + k]  = i_sinc3_result[8 * k +: 8];
      reg_hw_we[6 + k] = i_fast_done;                   // see [RULE9]
      reg_hw_d[6 + k]  = i_fast_result[8 * k +: 8];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_byte
      localparam logic [7:0] RV = (g == 2) ? acr_pkg::RST_GAIN_CAL_HIGH
                                           : acr_pkg::RST_ZERO; // see [RULE2]
      acr_byte_reg #(
        .RESET_VALUE (RV)
      ) u_byte (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_sw_we   (wr_strobe && (i_avs_address == reg_addr[g])),
        .i_sw_data (wdata),
        .i_hw_we   (reg_hw_we[g]),
        .i_hw_data (reg_hw_d[g]),
        .o_value   (reg_value[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // multiplexer control register

  logic [7:0] input_mux_control;

  // written by software only
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      input_mux_control <= acr_pkg::RST_ZERO;
    end else if (wr_strobe && i_avs_address == acr_pkg::ADDR_INPUT_MUX_CONTROL) begin
      input_mux_control <= wdata; // see [RULE8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [7:0] next_rdata;

  // select the addressed byte, zero for unmapped addresses
  always_comb begin
    next_rdata = acr_pkg::UNMAPPED_DATA;
    for (int k = 0; k < NUM_REGS; k++) begin
      if (i_avs_address == reg_addr[k]) begin
        next_rdata = reg_value[k];
      end
    end
    if (i_avs_address == acr_pkg::ADDR_INPUT_MUX_CONTROL) begin
      next_rdata = input_mux_control;
    end
  end

  // read data captured with the request, held until the next read
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && req) begin
      o_avs_readdata <= {24'h00_0000, next_rdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the converter core

  logic [3:0] pos_sel;
  logic [3:0] neg_sel;

  assign pos_sel = input_mux_control[acr_pkg::POS_SEL_LSB +: acr_pkg::SEL_W];
  assign neg_sel = input_mux_control[acr_pkg::NEG_SEL_LSB +: acr_pkg::SEL_W];

  // gain value follows the three byte registers
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_gain_cal <= {acr_pkg::RST_GAIN_CAL_HIGH, acr_pkg::RST_ZERO, acr_pkg::RST_ZERO};
    end else begin
      o_gain_cal <= {reg_value[2], reg_value[1], reg_value[0]}; // see [RULE1]
    end
  end

  // independent source decode for each converter input
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_positive_source_select <= 4'h0;
      o_negative_source_select <= 4'h0;
      o_positive_ext_en        <= 8'h01;
      o_negative_ext_en        <= 8'h01;
      o_positive_gnd_en        <= 1'b0;
      o_negative_gnd_en        <= 1'b0;
      o_positive_temp_en       <= 1'b0;
      o_negative_temp_en       <= 1'b0;
    end else begin
      o_positive_source_select <= pos_sel;                                          // see [RULE5]
      o_negative_source_select <= neg_sel;                                          // see [RULE5]
      o_positive_ext_en        <= ext_onehot(pos_sel);                              // see [RULE8]
      o_negative_ext_en        <= ext_onehot(neg_sel);                              // see [RULE8]
      o_positive_gnd_en        <= decode_src(pos_sel) == acr_pkg::ACR_SRC_GND;      // see [RULE7]
      o_negative_gnd_en        <= decode_src(neg_sel) == acr_pkg::ACR_SRC_GND;      // see [RULE7]
      o_positive_temp_en       <= decode_src(pos_sel) == acr_pkg::ACR_SRC_TEMP;     // see [RULE8]
      o_negative_temp_en       <= decode_src(neg_sel) == acr_pkg::ACR_SRC_TEMP;     // see [RULE8]
    end
  end

  // sensor powered whenever either input selects it
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_temp_sensor_en <= 1'b0;
    end else begin
      o_temp_sensor_en <= (pos_sel == acr_pkg::SEL_TEMP) || (neg_sel == acr_pkg::SEL_TEMP); // see [RULE6]
    end
  end

endmodule // acr_regs

`default_nettype wire

// File: acr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module acr_regs_properties (
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  // register bus
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic        o_avs_waitrequest,
  // converter side
  input wire logic [23:0] o_gain_cal,
  input wire logic [3:0]  o_positive_source_select,
  input wire logic [3:0]  o_negative_source_select,
  input wire logic [7:0]  o_positive_ext_en,
  input wire logic [7:0]  o_negative_ext_en,
  input wire logic        o_positive_gnd_en,
  input wire logic        o_negative_gnd_en,
  input wire logic        o_positive_temp_en,
  input wire logic        o_negative_temp_en,
  input wire logic        o_temp_sensor_en
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // a write accepted at the edge where waitrequest is low, at one address
  sequence wr_at(logic [7:0] a);
    i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && i_avs_address == a;
  endsequence
  one_wait_a: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait state");
  ack_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("acknowledge longer than one cycle");
  gain_reset_a: assert property ($rose(i_reset_n) |-> o_gain_cal == 24'h800000)
    else $error("gain calibration reset value wrong");
  reset_idle_a: assert property ($rose(i_reset_n) |-> o_avs_waitrequest &&
    o_temp_sensor_en == 1'b0)
    else $error("bus or sensor not idle after reset");
  gain_write_a: assert property (wr_at(acr_pkg::ADDR_GAIN_CAL_HIGH) |->
    ##2 o_gain_cal[23:16] == $past(i_avs_writedata[7:0], 2))
    else $error("gain high byte write not seen by core");
  mux_write_a: assert property (wr_at(acr_pkg::ADDR_INPUT_MUX_CONTROL) |->
    ##2 {o_positive_source_select, o_negative_source_select} == $past(i_avs_writedata[7:0], 2))
    else $error("mux write not seen on selects");
  temp_auto_a: assert property (o_temp_sensor_en ==
    (o_positive_source_select == 4'hf || o_negative_source_select == 4'hf))
    else $error("temperature sensor enable wrong");
  pos_decode_a: assert property (o_positive_ext_en ==
    (o_positive_source_select <= 4'h7 ? 8'h01 << o_positive_source_select : 8'h00))
    else $error("positive external enable wrong");
  neg_decode_a: assert property (o_negative_ext_en ==
    (o_negative_source_select <= 4'h7 ? 8'h01 << o_negative_source_select : 8'h00))
    else $error("negative external enable wrong");
  gnd_decode_a: assert property (
    o_negative_gnd_en == (o_negative_source_select inside {[4'h8:4'he]}) &&
    o_positive_gnd_en == (o_positive_source_select inside {[4'h8:4'he]}))
    else $error("ground enable wrong");
  temp_decode_a: assert property (
    o_positive_temp_en == (o_positive_source_select == 4'hf) &&
    o_negative_temp_en == (o_negative_source_select == 4'hf))
    else $error("temperature select wrong");
endmodule // acr_regs_properties
`default_nettype wire

// File: acr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module acr_core_model (
  // clock
  input  wire logic        i_sys_clk,
  // finished samples
  output logic             o_sinc3_done,
  output logic      [23:0] o_sinc3_result,
  output logic             o_fast_done,
  output logic      [23:0] o_fast_result
);
  // idle: no sample pending
  initial begin
    {o_sinc3_done, o_fast_done} = 2'b00;
    {o_sinc3_result, o_fast_result} = 48'h0;
  end
  // one sample after a gap, whole word beside a one-cycle done pulse
  task automatic deliver(input logic fast, input logic [23:0] v, input int gap);
    repeat (gap + 1) @(posedge i_sys_clk);
    if (fast) {o_fast_done, o_fast_result} <= {1'b1, v};
    else {o_sinc3_done, o_sinc3_result} <= {1'b1, v};
    @(posedge i_sys_clk);
    {o_sinc3_done, o_fast_done} <= 2'b00;
    // word is not held once the pulse is over
    {o_sinc3_result, o_fast_result} <= {~v, ~v};
  endtask
endmodule // acr_core_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_sys_clk, i_reset_n, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic        i_sinc3_done, i_fast_done, o_positive_gnd_en, o_negative_gnd_en;
  logic        o_positive_temp_en, o_negative_temp_en, o_temp_sensor_en;
  logic [7:0]  i_avs_address, o_positive_ext_en, o_negative_ext_en, m;
  logic [3:0]  i_avs_byteenable, o_positive_source_select, o_negative_source_select;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [23:0] i_sinc3_result, i_fast_result, o_gain_cal, v;
  logic [7:0]  addrs [11] = '{8'hab, 8'hac, 8'had, 8'hc3, 8'hc4, 8'hc5, 8'hc6,
                              8'hfc, 8'hfd, 8'hfe, 8'h00};
  int          fail_count, n_checks;

  acr_regs u_dut (.*);
  acr_core_model u_core (.i_sys_clk, .o_sinc3_done(i_sinc3_done),
    .o_sinc3_result(i_sinc3_result), .o_fast_done(i_fast_done), .o_fast_result(i_fast_result));

  // free-running clock
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t output %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    i_avs_address <= a;
    i_avs_writedata <= {24'($urandom), d};
    i_avs_read <= !w;
    i_avs_write <= w;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    q = o_avs_readdata;
    if (n >= 20) begin
      fail_count++;
      $display("mismatch %0t bus hung", $time);
      print_verdict();
    end
    {i_avs_read, i_avs_write} <= 2'b00;
    @(posedge i_sys_clk);
  endtask
  // expected decode of one nibble: ext, ground, temperature
  function automatic logic [9:0] dec(input logic [3:0] c);
    return {(c <= 4'h7) ? 8'h01 << c : 8'h00, c > 4'h7 && c != 4'hf, c == 4'hf};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'hd590));
    {i_reset_n, i_avs_read, i_avs_write} = 3'b000;
    {i_avs_address, i_avs_writedata, i_avs_byteenable} = 44'h1;
    fail_count = 0;
    n_checks = 0;
    repeat (5) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    // reset content, unmapped place included
    foreach (addrs[k]) begin
      bus(1'b0, addrs[k], 8'h00);
      chk_reg(q, {24'h0, addrs[k] == 8'had ? 8'h80 : 8'h00});
    end
    chk_out(o_gain_cal, 24'h800000);
    // gain words through three bytes: all ones first, then two random words
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 24'hffffff : 24'($urandom);
      bus(1'b1, 8'hab, v[7:0]);
      bus(1'b1, 8'hac, v[15:8]);
      bus(1'b1, 8'had, v[23:16]);
      bus(1'b0, 8'hac, 8'h00);
      chk_reg(q, {24'h0, v[15:8]});
      chk_out(o_gain_cal, v);
    end
    // writes without byte enable or to no register change nothing
    i_avs_byteenable <= 4'h0;
    bus(1'b1, 8'had, 8'h5a);
    i_avs_byteenable <= 4'h1;
    bus(1'b1, 8'h00, 8'h5a);
    bus(1'b0, 8'had, 8'h00);
    chk_reg(q, {24'h0, v[23:16]});
    bus(1'b0, 8'h00, 8'h00);
    chk_reg(q, 32'h0);
    // every source code on both inputs; decode outputs lag the register by one edge
    for (int c = 0; c < 16; c++) begin
      m = {4'(c), 4'(15 - c)};
      bus(1'b1, 8'hc6, m);
      @(posedge i_sys_clk);
      chk_out({o_positive_ext_en, o_positive_gnd_en, o_positive_temp_en}, dec(m[7:4]));
      chk_out({o_negative_ext_en, o_negative_gnd_en, o_negative_temp_en}, dec(m[3:0]));
      chk_out(o_temp_sensor_en, m[7:4] == 4'hf || m[3:0] == 4'hf);
      bus(1'b0, 8'hc6, 8'h00);
      chk_reg(q, {24'h0, m});
    end
    // samples from both filters, read low to high
    for (int i = 0; i < 4; i++) begin
      v = 24'($urandom);
      u_core.deliver(i[0], v, $urandom_range(3));
      for (int b = 0; b < 3; b++) begin
        bus(1'b0, (i[0] ? 8'hfc : 8'hc3) + 8'(b), 8'h00);
        chk_reg(q, {24'h0, v[8*b +: 8]});
      end
    end
    // result bytes take software writes
    bus(1'b1, 8'hfd, 8'ha5);
    bus(1'b0, 8'hfd, 8'h00);
    chk_reg(q, 32'ha5);
    // reset in mid-run brings every written byte back to its reset value
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    bus(1'b0, 8'had, 8'h00);
    chk_reg(q, 32'h80);
    bus(1'b0, 8'hfd, 8'h00);
    chk_reg(q, 32'h0);
    bus(1'b0, 8'hc6, 8'h00);
    chk_reg(q, 32'h0);
    chk_out(o_gain_cal, 24'h800000);
    print_verdict();
  end
endmodule // tb
bind acr_regs acr_regs_properties u_props (.*);
`default_nettype wire
